/* File: dsa_pkg.sv */
// Shared constants for the arithmetic slice and its controlling logic.
package dsa_pkg;
  // ----------------------------------------------------------------
  // Datapath sizes
  // ----------------------------------------------------------------
  localparam int OPERAND_W   = 18;
  localparam int RESULT_W    = 48;
  localparam int SHIFT_BITS  = 17;
  localparam int SELECT_W    = 7;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 48'h0;
  // ----------------------------------------------------------------
  // Select code fields
  // ----------------------------------------------------------------
  localparam int X_LSB = 0;
  localparam int Y_LSB = 2;
  localparam int Z_LSB = 4;
  localparam logic [1:0] X_ZERO    = 2'h0;
  localparam logic [1:0] X_PROD    = 2'h1;
  localparam logic [1:0] X_RESULT  = 2'h2;
  localparam logic [1:0] X_CONCAT  = 2'h3;
  localparam logic [1:0] Y_ZERO    = 2'h0;
  localparam logic [1:0] Y_PROD    = 2'h1;
  localparam logic [1:0] Y_ILLEGAL = 2'h2;
  localparam logic [1:0] Y_ADDEND  = 2'h3;
  localparam logic [2:0] Z_ZERO    = 3'h0;
  localparam logic [2:0] Z_CASCADE = 3'h1;
  localparam logic [2:0] Z_RESULT  = 3'h2;
  localparam logic [2:0] Z_ADDEND  = 3'h3;
  localparam logic [2:0] Z_SHCASC  = 3'h5;
  localparam logic [2:0] Z_SHRES   = 3'h6;
  localparam logic [SELECT_W-1:0] SEL_COUNT   = 7'h20;
  localparam logic [SELECT_W-1:0] SEL_PRELOAD = 7'h30;
  localparam logic [SELECT_W-1:0] SEL_RESET   = 7'h00;
  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OPA     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OPB     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ADD_LO  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ADD_HI  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RES_LO  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RES_HI  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h1c;
  localparam int CTL_SUB     = 7;
  localparam int CTL_CARRY   = 8;
  localparam int CTL_DOWN    = 9;
  localparam int CTL_PRELOAD = 10;
  localparam int CTL_MUX     = 11;
  localparam int CTL_MUXSEL  = 12;
  localparam int CTL_COUNT   = 14;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0;
  localparam logic [1:0] MUX_X = 2'h0;
  localparam logic [1:0] MUX_Y = 2'h1;
  localparam logic [1:0] MUX_Z = 2'h2;
  typedef enum logic [1:0] {DSA_IDLE, DSA_LOAD, DSA_COUNT} dsa_state_t;
endpackage : dsa_pkg

/* File: dsa_link_if.sv */
// Connection between the controlling logic and the arithmetic slice.
interface dsa_link_if;
  import dsa_pkg::*;
  logic [SELECT_W-1:0]  operandSelectCode;
  logic                 subtract;
  logic                 carryInput;
  logic [OPERAND_W-1:0] operandA;
  logic [OPERAND_W-1:0] operandB;
  logic [RESULT_W-1:0]  addend;
  logic [RESULT_W-1:0]  result;
  logic                 illegalSelect;

  modport slice (
    input  operandSelectCode,
    input  subtract,
    input  carryInput,
    input  operandA,
    input  operandB,
    input  addend,
    output result,
    output illegalSelect
  );

  modport ctrl (
    output operandSelectCode,
    output subtract,
    output carryInput,
    output operandA,
    output operandB,
    output addend,
    input  result,
    input  illegalSelect
  );
endinterface : dsa_link_if

/* File: dsa_slice.sv */
// Arithmetic slice: operand multiplexers, multiplier and adder/subtracter.
module dsa_slice
  import dsa_pkg::*;
#(
  parameter int AW = OPERAND_W,
  parameter int PW = RESULT_W,
  parameter int SH = SHIFT_BITS
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  dsa_link_if.slice          link,
  input  wire logic [PW-1:0] cascadeInput,
  output logic      [PW-1:0] cascadeOutput
);

  // ----------------------------------------------------------------
  // Select code fields
  // ----------------------------------------------------------------
  logic [1:0] xSel;
  logic [1:0] ySel;
  logic [2:0] zSel;

  assign xSel = link.operandSelectCode[X_LSB +: 2];
  assign ySel = link.operandSelectCode[Y_LSB +: 2];
  assign zSel = link.operandSelectCode[Z_LSB +: 3];

  // ----------------------------------------------------------------
  // Multiplier and wide operands
  // ----------------------------------------------------------------
  logic signed [2*AW-1:0] product;
  logic        [PW-1:0]   productWide;
  logic        [2*AW-1:0] concatRaw;
  logic        [PW-1:0]   concatWide;
  logic        [PW-1:0]   shiftedResult;
  logic        [PW-1:0]   shiftedCascadeInput;

  // Signed 18 by 18 multiply; a power of two on B gives the rotate shift.
  assign product = $signed(link.operandA) * $signed(link.operandB);

  // Sign extension keeps products two's complement over the full width.
  assign productWide = {{(PW-2*AW){product[2*AW-1]}}, product};

  assign concatRaw  = {link.operandA, link.operandB};
  assign concatWide = {{(PW-2*AW){concatRaw[2*AW-1]}}, concatRaw};

  // Arithmetic shifts; a non-negative rotate value stays free of fill bits.
  assign shiftedResult       = $signed(link.result) >>> SH;
  assign shiftedCascadeInput = $signed(cascadeInput) >>> SH;

  // ----------------------------------------------------------------
  // X multiplexer
  // ----------------------------------------------------------------
  logic [PW-1:0] xOperand;

  always_comb begin
    unique case (xSel)
      X_ZERO:   xOperand = '0;
      X_PROD:   xOperand = productWide;
      X_RESULT: xOperand = link.result;
      X_CONCAT: xOperand = concatWide;
    endcase
  end

  // ----------------------------------------------------------------
  // Y multiplexer
  // ----------------------------------------------------------------
  // The product is counted once: X carries it and Y adds nothing, so
  // the pair only makes sense when both select it together.
  logic [PW-1:0] yOperand;

  always_comb begin
    unique case (ySel)
      Y_ZERO:    yOperand = '0;
      Y_PROD:    yOperand = '0;
      Y_ILLEGAL: yOperand = '0;
      Y_ADDEND:  yOperand = link.addend;
    endcase
  end

  // ----------------------------------------------------------------
  // Z multiplexer
  // ----------------------------------------------------------------
  logic [PW-1:0] zOperand;
  logic          zIllegal;

  always_comb begin
    zIllegal = 1'b0;
    unique case (zSel)
      Z_ZERO:    zOperand = '0;
      Z_CASCADE: zOperand = cascadeInput;
      Z_RESULT:  zOperand = link.result;
      Z_ADDEND:  zOperand = link.addend;
      Z_SHCASC:  zOperand = shiftedCascadeInput;
      Z_SHRES:   zOperand = shiftedResult;
      default: begin
        zOperand = '0;
        zIllegal = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Adder/subtracter
  // ----------------------------------------------------------------
  logic [PW-1:0] carryWide;
  logic [PW-1:0] xySum;
  logic [PW-1:0] next_result;

  assign carryWide = {{(PW-1){1'b0}}, link.carryInput};
  assign xySum     = xOperand + yOperand + carryWide;

  always_comb begin
    if (link.subtract) begin
      next_result = zOperand - xySum;
    end else begin
      next_result = zOperand + xySum;
    end
  end

  // ----------------------------------------------------------------
  // Illegal selection detect
  // ----------------------------------------------------------------
  // A lone product half would give a meaningless sum; it is flagged
  // rather than blocked, the arithmetic still runs.
  logic productSplit;
  logic next_illegal;

  assign productSplit = (xSel == X_PROD) != (ySel == Y_PROD);
  assign next_illegal = productSplit || (ySel == Y_ILLEGAL) || zIllegal;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.illegalSelect <= 1'b0;
    end else begin
      link.illegalSelect <= next_illegal;
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.result <= RESULT_RESET;
    end else begin
      link.result <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Cascade output
  // ----------------------------------------------------------------
  // A separate copy keeps the output straight from a flip-flop while
  // matching the result register in every cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cascadeOutput <= RESULT_RESET;
    end else begin
      cascadeOutput <= next_result;
    end
  end

endmodule : dsa_slice

/* File: dsa_ctrl.sv */
// Controlling logic: register port for software, drives the slice.
//
// Our own choices: the plain strobed port and the register offsets.
module dsa_ctrl
  import dsa_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  dsa_link_if.ctrl               link,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWriteData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regReadData
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]    control;
  logic [OPERAND_W-1:0] opA;
  logic [OPERAND_W-1:0] opB;
  logic [RESULT_W-1:0]  addendReg;
  logic                 controlWrite;

  assign controlWrite = regWrite && (regAddr == REG_CONTROL);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control   <= CONTROL_RESET;
      opA       <= '0;
      opB       <= '0;
      addendReg <= '0;
    end else if (regWrite) begin
      unique case (regAddr)
        REG_CONTROL: control <= regWriteData;
        REG_OPA:     opA <= regWriteData[OPERAND_W-1:0];
        REG_OPB:     opB <= regWriteData[OPERAND_W-1:0];
        REG_ADD_LO:  addendReg[DATA_W-1:0] <= regWriteData;
        REG_ADD_HI:  addendReg[RESULT_W-1:DATA_W] <= regWriteData[RESULT_W-DATA_W-1:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter sequencing
  // ----------------------------------------------------------------
  dsa_state_t state;
  dsa_state_t next_state;

  always_comb begin
    next_state = state;
    if (controlWrite) begin
      if (regWriteData[CTL_PRELOAD]) begin
        next_state = DSA_LOAD;
      end else if (regWriteData[CTL_COUNT]) begin
        next_state = DSA_COUNT;
      end else begin
        next_state = DSA_IDLE;
      end
    end else if (state == DSA_LOAD) begin
      next_state = DSA_COUNT;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= DSA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Selection policing
  // ----------------------------------------------------------------
  // Software may write any code; what leaves here always obeys the
  // pairing restriction of the slice, which overrides a single-mux select of a product.
  logic [SELECT_W-1:0] userSel;
  logic [SELECT_W-1:0] next_sel;
  logic                next_sub;
  logic                next_carry;

  always_comb begin
    userSel = control[SELECT_W-1:0];
    if (control[CTL_MUX]) begin
      unique case (control[CTL_MUXSEL +: 2])
        MUX_Y:   userSel = {Z_ZERO, userSel[Y_LSB +: 2], X_ZERO};
        MUX_Z:   userSel = {userSel[Z_LSB +: 3], Y_ZERO, X_ZERO};
        default: userSel = {Z_ZERO, Y_ZERO, userSel[X_LSB +: 2]};
      endcase
    end
    if (userSel[X_LSB +: 2] == X_PROD || userSel[Y_LSB +: 2] == Y_PROD) begin
      userSel = {userSel[Z_LSB +: 3], Y_PROD, X_PROD};
    end
    unique case (state)
      DSA_LOAD: begin
        next_sel   = SEL_PRELOAD;
        next_sub   = 1'b0;
        next_carry = 1'b1;
      end
      DSA_COUNT: begin
        next_sel   = SEL_COUNT;
        next_sub   = control[CTL_DOWN];
        next_carry = 1'b1;
      end
      DSA_IDLE: begin
        next_sel   = userSel;
        next_sub   = control[CTL_SUB];
        next_carry = control[CTL_CARRY];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Drive to the slice
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.operandSelectCode <= SEL_RESET;
      link.subtract          <= 1'b0;
      link.carryInput        <= 1'b0;
      link.operandA          <= '0;
      link.operandB          <= '0;
      link.addend            <= '0;
    end else begin
      link.operandSelectCode <= next_sel;
      link.subtract          <= next_sub;
      link.carryInput        <= next_carry;
      link.operandA          <= opA;
      link.operandB          <= opB;
      link.addend            <= addendReg;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regReadData <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        REG_CONTROL: regReadData <= control;
        REG_OPA:     regReadData <= {{(DATA_W-OPERAND_W){1'b0}}, opA};
        REG_OPB:     regReadData <= {{(DATA_W-OPERAND_W){1'b0}}, opB};
        REG_ADD_LO:  regReadData <= addendReg[DATA_W-1:0];
        REG_ADD_HI:  regReadData <= {16'h0, addendReg[RESULT_W-1:DATA_W]};
        REG_RES_LO:  regReadData <= link.result[DATA_W-1:0];
        REG_RES_HI:  regReadData <= {16'h0, link.result[RESULT_W-1:DATA_W]};
        REG_STATUS:  regReadData <= {29'h0, state == DSA_COUNT, state == DSA_LOAD,
                                     link.illegalSelect};
        default:     regReadData <= '0;
      endcase
    end else begin
      regReadData <= '0;
    end
  end

endmodule : dsa_ctrl

/* File: dsa_model_pkg.sv */
// Reference arithmetic of the slice, shared by the bench and its checker.
package dsa_model_pkg;
  import dsa_pkg::*;
  function automatic logic [RESULT_W-1:0] calc(
    input logic [SELECT_W-1:0] s, input logic sb, input logic ci,
    input logic [OPERAND_W-1:0] a, input logic [OPERAND_W-1:0] b,
    input logic [RESULT_W-1:0] c, input logic [RESULT_W-1:0] p,
    input logic [RESULT_W-1:0] pc);
    logic [RESULT_W-1:0] x, y, z;
    case (s[1:0])
      X_PROD:   x = $signed(a) * $signed(b);
      X_RESULT: x = p;
      X_CONCAT: x = {{12{a[17]}}, a, b};
      default:  x = 48'h0;
    endcase
    // A lone product code on Y adds nothing; the product is carried by X.
    y = (s[3:2] == Y_ADDEND) ? c : 48'h0;
    case (s[6:4])
      Z_CASCADE: z = pc;
      Z_RESULT:  z = p;
      Z_ADDEND:  z = c;
      Z_SHCASC:  z = $signed(pc) >>> SHIFT_BITS;
      Z_SHRES:   z = $signed(p) >>> SHIFT_BITS;
      default:   z = 48'h0;
    endcase
    return sb ? z - (x + y + ci) : z + (x + y + ci);
  endfunction : calc
endpackage : dsa_model_pkg

/* File: dsa_link_asserts.sv */
// Concurrent checks on the link between the controlling logic and the slice.
module dsa_link_asserts
  import dsa_pkg::*;
  import dsa_model_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic [SELECT_W-1:0]  operandSelectCode,
  input wire logic                 subtract,
  input wire logic                 carryInput,
  input wire logic [OPERAND_W-1:0] operandA,
  input wire logic [OPERAND_W-1:0] operandB,
  input wire logic [RESULT_W-1:0]  addend,
  input wire logic [RESULT_W-1:0]  result,
  input wire logic                 illegalSelect,
  input wire logic [RESULT_W-1:0]  cascadeInput,
  input wire logic [RESULT_W-1:0]  cascadeOutput
);
  logic [RESULT_W-1:0] expRes;
  wire logic [RESULT_W-1:0] cat = {{12{operandA[17]}}, operandA, operandB};
  wire logic [RESULT_W-1:0] prod = $signed(operandA) * $signed(operandB);
  wire logic [RESULT_W-1:0] shRes = $signed(result) >>> SHIFT_BITS;
  wire logic [SELECT_W-1:0] sel = operandSelectCode;
  wire logic illNow = sel[3:2] == Y_ILLEGAL || sel[6:4] == 3'h4 || sel[6:4] == 3'h7
                      || ((sel[1:0] == X_PROD) != (sel[3:2] == Y_PROD));
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      expRes <= RESULT_RESET;
    end else begin
      expRes <= calc(sel, subtract, carryInput, operandA, operandB, addend, result, cascadeInput);
    end
  end
  property p_sum; result == expRes; endproperty
  a_sum: assert property (p_sum) else $error("result differs from operand sum");
  property p_mirror; cascadeOutput == result; endproperty
  a_mirror: assert property (p_mirror) else $error("cascade output differs");
  property p_illegal; illegalSelect == $past(illNow); endproperty
  a_illegal: assert property (p_illegal) else $error("illegal flag wrong");
  property p_pair; (sel[1:0] == X_PROD) == (sel[3:2] == Y_PROD); endproperty
  a_pair: assert property (p_pair) else $error("product on one mux only");
  property p_count; sel == SEL_COUNT && carryInput && !subtract |=> result == $past(result) + 1;
  endproperty
  a_count: assert property (p_count) else $error("count up step wrong");
  property p_down; sel == SEL_COUNT && carryInput && subtract |=> result == $past(result) - 1;
  endproperty
  a_down: assert property (p_down) else $error("count down step wrong");
  property p_preload;
    sel == SEL_PRELOAD && carryInput && !subtract |=> result == $past(addend) + 1;
  endproperty
  a_preload: assert property (p_preload) else $error("preload value wrong");
  property p_cascade; sel == 7'h10 && !carryInput |=> result == $past(cascadeInput); endproperty
  a_cascade: assert property (p_cascade) else $error("cascade pass wrong");
  property p_accum;
    sel == 7'h2f && !subtract && !carryInput
      |=> result == $past(result) + $past(cat) + $past(addend);
  endproperty
  a_accum: assert property (p_accum) else $error("accumulate wrong");
  property p_shres;
    sel == 7'h6f && !subtract && !carryInput
      |=> result == $past(shRes) + $past(cat) + $past(addend);
  endproperty
  a_shres: assert property (p_shres) else $error("shifted accumulate wrong");
  property p_mac; sel == 7'h05 && !subtract && !carryInput |=> result == $past(prod); endproperty
  a_mac: assert property (p_mac) else $error("product wrong");
  c_count: cover property (sel == SEL_COUNT && carryInput);
  c_preload: cover property (sel == SEL_PRELOAD && carryInput);
  c_rotate: cover property (sel == 7'h55);
  c_illegal: cover property (illegalSelect);
endmodule : dsa_link_asserts

/* File: dsa_slice_arith_datapath_test.sv */
// Self-checking bench: controller and slice joined over the link interface.
module dsa_slice_arith_datapath_test
  import dsa_pkg::*;
  import dsa_model_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regReadData;
  logic [RESULT_W-1:0] cascadeIn = 48'h0;
  logic [RESULT_W-1:0] cascadeOut;
  int nFail = 0;
  int checksDone = 0;
  int seed = 93;
  logic [3:0] xyTab [5] = '{4'h0, 4'h3, 4'hc, 4'hf, 4'h5};
  logic [2:0] zTab [4] = '{Z_ZERO, Z_CASCADE, Z_ADDEND, Z_SHCASC};
  logic [6:0] illTab [4] = '{7'h08, 7'h40, 7'h70, 7'h01};
  logic [6:0] muxTab [3] = '{7'h03, 7'h0c, 7'h30};
  always #12.5 ref_clk = ~ref_clk;
  dsa_link_if dsa_link_if_i ();
  dsa_slice dsa_slice_i (.ref_clk(ref_clk), .rst(rst), .link(dsa_link_if_i.slice),
    .cascadeInput(cascadeIn), .cascadeOutput(cascadeOut));
  dsa_ctrl dsa_ctrl_i (.ref_clk(ref_clk), .rst(rst), .link(dsa_link_if_i.ctrl),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData));
  dsa_link_asserts dsa_link_asserts_i (.ref_clk(ref_clk), .rst(rst),
    .operandSelectCode(dsa_link_if_i.operandSelectCode), .subtract(dsa_link_if_i.subtract),
    .carryInput(dsa_link_if_i.carryInput), .operandA(dsa_link_if_i.operandA),
    .operandB(dsa_link_if_i.operandB), .addend(dsa_link_if_i.addend),
    .result(dsa_link_if_i.result), .illegalSelect(dsa_link_if_i.illegalSelect),
    .cascadeInput(cascadeIn), .cascadeOutput(cascadeOut));
  task automatic testDone();
    $display("Checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : testDone
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Strobes are left high so back-to-back transfers never assign twice at one edge.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge ref_clk);
    #1;
    d = regReadData;
  endtask : rd
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic countRun(input logic [31:0] ctl, input logic [47:0] first, input logic [47:0] step);
    int w;
    logic [DATA_W-1:0] st;
    wr(REG_CONTROL, CONTROL_RESET);
    idle(3);
    wr(REG_CONTROL, ctl);
    // The first count value must land exactly two edges after the control write.
    idle(2);
    check("counter first", dsa_link_if_i.result, first);
    for (w = 1; w < 6; w++) begin
      idle(1);
      check("counter step", dsa_link_if_i.result, first + 48'(w) * step);
    end
    rd(REG_STATUS, st);
    check("counting flag", 48'(st[2:1]), 48'h2);
  endtask : countRun
  initial begin
    logic [31:0] d, h;
    logic [47:0] c, pc, e;
    logic [17:0] a, b;
    logic [6:0] s;
    logic sb, ci;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_CONTROL, d);
    check("control reset", 48'(d), 48'(CONTROL_RESET));
    rd(REG_RES_LO, d);
    check("result reset", 48'(d), 48'h0);
    rd(8'h20, d);
    check("unmapped read", 48'(d), 48'h0);
    for (int i = 0; i < 30; i++) begin
      a = (i == 0) ? 18'h20000 : 18'($random(seed));
      b = (i < 2) ? 18'h20000 : 18'($random(seed));
      c = {16'($random(seed)), 32'($random(seed))};
      pc = {16'($random(seed)), 32'($random(seed))};
      s = {zTab[2'($random(seed))], xyTab[$unsigned($random(seed)) % 5]};
      sb = 1'($random(seed));
      ci = 1'($random(seed));
      if (i == 2) begin
        s = 7'h10;
        ci = 1'b0;
      end
      cascadeIn <= pc;
      wr(REG_OPA, 32'(a));
      wr(REG_OPB, 32'(b));
      wr(REG_ADD_LO, c[31:0]);
      wr(REG_ADD_HI, 32'(c[47:32]));
      wr(REG_CONTROL, 32'(s) | (32'(sb) << CTL_SUB) | (32'(ci) << CTL_CARRY));
      idle(3);
      rd(REG_RES_LO, d);
      rd(REG_RES_HI, h);
      check("sum", {h[15:0], d}, calc(s, sb, ci, a, b, c, 48'h0, pc));
    end
    wr(REG_CONTROL, 32'h2f);
    idle(4);
    wr(REG_CONTROL, 32'h6f);
    idle(4);
    wr(REG_CONTROL, 32'h0e);
    idle(4);
    foreach (illTab[i]) begin
      wr(REG_CONTROL, 32'(illTab[i]));
      idle(3);
      rd(REG_STATUS, d);
      check("illegal flag", 48'(d[0]), 48'(i < 3));
    end
    for (int m = 0; m < 3; m++) begin
      wr(REG_CONTROL, 32'h3f | (32'h1 << CTL_MUX) | (32'(m) << CTL_MUXSEL));
      idle(2);
      check("mux select", 48'(dsa_link_if_i.operandSelectCode), 48'(muxTab[m]));
    end
    for (int n = 0; n < 17; n++) begin
      a = 18'($random(seed));
      wr(REG_OPA, 32'({1'b0, a[17:1]}));
      wr(REG_OPB, 32'h1 << n);
      wr(REG_CONTROL, 32'h05);
      idle(3);
      check("rotate stage one", cascadeOut, 48'({1'b0, a[17:1]}) << n);
      cascadeIn <= cascadeOut;
      wr(REG_OPA, 32'(a));
      wr(REG_CONTROL, 32'h55);
      idle(3);
      rd(REG_RES_LO, d);
      e = 48'({a, a}) << n;
      check("rotate result", 48'(d[17:0]), 48'(e[35:18]));
    end
    wr(REG_ADD_LO, 32'h1234);
    wr(REG_ADD_HI, 32'h0);
    countRun(32'h1 << CTL_COUNT, 48'h1, 48'h1);
    countRun(32'h1 << CTL_COUNT | 32'h1 << CTL_DOWN, 48'hffffffffffff, 48'hffffffffffff);
    countRun(32'h1 << CTL_COUNT | 32'h1 << CTL_PRELOAD, 48'h1235, 48'h1);
    countRun(32'h1 << CTL_PRELOAD | 32'h1 << CTL_DOWN, 48'h1235, 48'hffffffffffff);
    rst <= 1'b1;
    idle(1);
    check("result in reset", dsa_link_if_i.result, 48'h0);
    rst <= 1'b0;
    rd(REG_CONTROL, d);
    check("control after reset", 48'(d), 48'(CONTROL_RESET));
    idle(1);
    testDone();
  end
  // The full run needs about 610 cycles; the 20000-cycle limit leaves a wide margin.
  initial begin
    #(25 * 20000);
    nFail++;
    testDone();
  end
endmodule : dsa_slice_arith_datapath_test
